// ---- core/nibble_add_consts.svh ----
// opcode prefixes, address layout and reset values of the nibble add unit
`ifndef NIBBLE_ADD_CONSTS_SVH
`define NIBBLE_ADD_CONSTS_SVH

// ------------------------------------------------------------
// memory-operand prefixes, instr[15:7]
// ------------------------------------------------------------
`define NA_PFX_ADC_M 9'h020
`define NA_PFX_ADCW_M 9'h012
`define NA_PFX_ADD_M 9'h030
`define NA_PFX_ADDW_M 9'h032
`define NA_PFX_ADU_M 9'h050

// ------------------------------------------------------------
// immediate-operand prefixes, instr[15:8]
// ------------------------------------------------------------
`define NA_PFX_ADC_I 8'h0C
`define NA_PFX_ADCW_I 8'h0D
`define NA_PFX_ADD_I 8'h1C
`define NA_PFX_ADDW_I 8'h1D

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define NA_MPFX_LSB 7
`define NA_IPFX_LSB 8
`define NA_IMM_LSB 4

// ------------------------------------------------------------
// data memory layout and reset values
// ------------------------------------------------------------
`define NA_MEM_DEPTH 128
`define NA_WR_BASE 7'h00
`define NA_ACC_RST 4'h0
`define NA_CARRY_RST 1'b0
`define NA_ZERO_RST 1'b0

`endif

// ---- core/nibble_add_instruction_unit.sv ----
// nibble add instruction unit: decode, add, flag update and write-back
`timescale 1ns/1ps
`default_nettype none
`include "nibble_add_consts.svh"

// Function
// - adc memory: acc gets mem+acc+carry
// - adc immediate: acc gets wr+imm+carry
// - adc memory writeback: acc and mem
// - adc immediate writeback: acc and wr
// - add memory: acc gets mem+acc
// - add immediate: acc gets wr+imm
// - add memory writeback, no carry in
// - add immediate writeback, no carry in
// - add memory keeping carry, zero only
module nibble_add_instruction_unit
	import nibble_add_pkg::*;
#(
	parameter int MEM_DEPTH = `NA_MEM_DEPTH
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// instruction stream
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	output logic ready,
	output logic done,
	output logic illegal,
	// core state
	output logic [3:0] accumulator,
	output logic carry_flag,
	output logic zero_flag,
	// data memory access while idle
	input wire logic ext_we,
	input wire logic ext_re,
	input wire logic [6:0] ext_addr,
	input wire logic [3:0] ext_wdata,
	output logic [3:0] ext_rdata,
	output logic ext_rvalid
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic op_t decode(input logic [15:0] w);
		op_t o;
		o = OP_NONE;
		case (w[15:`NA_MPFX_LSB])
			`NA_PFX_ADC_M: o = OP_ADC_M;
			`NA_PFX_ADCW_M: o = OP_ADCW_M;
			`NA_PFX_ADD_M: o = OP_ADD_M;
			`NA_PFX_ADDW_M: o = OP_ADDW_M;
			`NA_PFX_ADU_M: o = OP_ADU_M;
			default: begin
				case (w[15:`NA_IPFX_LSB])
					`NA_PFX_ADC_I: o = OP_ADC_I;
					`NA_PFX_ADCW_I: o = OP_ADCW_I;
					`NA_PFX_ADD_I: o = OP_ADD_I;
					`NA_PFX_ADDW_I: o = OP_ADDW_I;
					default: o = OP_NONE;
				endcase
			end
		endcase
		return o;
	endfunction

	function automatic logic is_imm(input op_t o);
		return (o == OP_ADC_I) || (o == OP_ADCW_I) || (o == OP_ADD_I) || (o == OP_ADDW_I);
	endfunction
	function automatic logic uses_cin(input op_t o);
		return o inside {OP_ADC_M, OP_ADC_I, OP_ADCW_M, OP_ADCW_I};
	endfunction
	function automatic logic writes_back(input op_t o);
		return o inside {OP_ADCW_M, OP_ADCW_I, OP_ADDW_M, OP_ADDW_I};
	endfunction

	// working registers sit in a fixed window of data memory
	function automatic logic [6:0] operand_addr(input logic [15:0] w);
		if (is_imm(decode(w))) begin
			return 7'(`NA_WR_BASE + {3'h0, w[3:0]});
		end
		return w[6:0];
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	state_t state_r, state_nxt;
	op_t op_r, op_nxt;
	logic [3:0] imm_r, imm_nxt;
	logic [6:0] addr_r, addr_nxt;
	logic [3:0] acc_r, acc_nxt;
	logic carry_r, carry_nxt;
	logic zero_r, zero_nxt;
	logic ready_r, ready_nxt;
	logic done_r, done_nxt;
	logic illegal_r, illegal_nxt;
	logic rd_pend_r, rd_pend_nxt;
	logic [3:0] ext_rdata_r, ext_rdata_nxt;
	logic ext_rvalid_r, ext_rvalid_nxt;
	logic ram_we;
	logic [6:0] ram_addr;
	logic [3:0] ram_wdata, ram_rdata, operand_b;
	logic cin;
	logic [4:0] sum5;
	logic take;

	nibble_ram #(.DEPTH(MEM_DEPTH), .AW(7), .DW(4)) u_ram (
		.clk(clk),
		.rstn(rstn),
		.en(ce),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	// ------------------------------------------------------------
	// adder
	// ------------------------------------------------------------
	always_comb begin
		operand_b = is_imm(op_r) ? imm_r : acc_r;
		cin = uses_cin(op_r) ? carry_r : 1'b0;
		sum5 = {1'b0, ram_rdata} + {1'b0, operand_b} + {4'h0, cin};
	end
	assign take = ready_r && instr_valid;

	// ------------------------------------------------------------
	// memory port steering
	// ------------------------------------------------------------
	// an instruction owns the port; outside access only while nothing is offered
	always_comb begin
		ram_we = 1'b0;
		ram_addr = ext_addr;
		ram_wdata = ext_wdata;
		if (state_r == S_EXEC) begin
			ram_we = writes_back(op_r);
			ram_addr = addr_r;
			ram_wdata = sum5[3:0];
		end else if (take) begin
			ram_addr = operand_addr(instr);
		end else begin
			ram_we = ext_we;
		end
	end

	// ------------------------------------------------------------
	// sequencing and flags
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		imm_nxt = imm_r;
		addr_nxt = addr_r;
		acc_nxt = acc_r;
		carry_nxt = carry_r;
		zero_nxt = zero_r;
		ready_nxt = ready_r;
		done_nxt = 1'b0;
		illegal_nxt = 1'b0;
		rd_pend_nxt = (state_r == S_IDLE) && !take && ext_re;
		ext_rdata_nxt = rd_pend_r ? ram_rdata : ext_rdata_r;
		ext_rvalid_nxt = rd_pend_r;
		case (state_r)
			S_IDLE: begin
				if (take) begin
					if (decode(instr) == OP_NONE) begin
						illegal_nxt = 1'b1;
					end else begin
						state_nxt = S_EXEC;
						op_nxt = decode(instr);
						imm_nxt = instr[`NA_IMM_LSB +: 4];
						addr_nxt = operand_addr(instr);
						ready_nxt = 1'b0;
					end
				end
			end
			S_EXEC: begin
				acc_nxt = sum5[3:0];
				zero_nxt = (sum5[3:0] == 4'h0);
				if (op_r != OP_ADU_M) begin
					carry_nxt = sum5[4];
				end
				done_nxt = 1'b1;
				ready_nxt = 1'b1;
				state_nxt = S_IDLE;
			end
			default: begin
				state_nxt = S_IDLE;
				ready_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= S_IDLE;
			op_r <= OP_NONE;
			imm_r <= 4'h0;
			addr_r <= 7'h00;
			acc_r <= `NA_ACC_RST;
			carry_r <= `NA_CARRY_RST;
			zero_r <= `NA_ZERO_RST;
			ready_r <= 1'b1;
			done_r <= 1'b0;
			illegal_r <= 1'b0;
			rd_pend_r <= 1'b0;
			ext_rdata_r <= 4'h0;
			ext_rvalid_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			imm_r <= imm_nxt;
			addr_r <= addr_nxt;
			acc_r <= acc_nxt;
			carry_r <= carry_nxt;
			zero_r <= zero_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
			illegal_r <= illegal_nxt;
			rd_pend_r <= rd_pend_nxt;
			ext_rdata_r <= ext_rdata_nxt;
			ext_rvalid_r <= ext_rvalid_nxt;
		end
	end

	assign ready = ready_r;
	assign done = done_r;
	assign illegal = illegal_r;
	assign accumulator = acc_r;
	assign carry_flag = carry_r;
	assign zero_flag = zero_r;
	assign ext_rdata = ext_rdata_r;
	assign ext_rvalid = ext_rvalid_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire exec_ce = (state_r == S_EXEC) && ce;
	sequence s_take_legal;
		ce && take && (decode(instr) != OP_NONE);
	endsequence
	sequence s_take_imm;
		ce && take && is_imm(decode(instr));
	endsequence
	sequence s_exec_step;
		ce && (state_r == S_EXEC);
	endsequence

	a_adc_mem_sum: assert property (exec_ce && op_r == OP_ADC_M |=>
		accumulator == 4'($past(ram_rdata) + $past(acc_r) + {3'h0, $past(carry_r)}))
		else $error("adc memory sum wrong");
	a_adc_imm_sum: assert property (exec_ce && op_r == OP_ADC_I |=>
		accumulator == 4'($past(ram_rdata) + $past(imm_r) + {3'h0, $past(carry_r)}))
		else $error("adc immediate sum wrong");
	a_adcw_mem_write: assert property (exec_ce && op_r == OP_ADCW_M |->
		ram_we && ram_addr == addr_r && ram_wdata == 4'(ram_rdata + acc_r + {3'h0, carry_r}))
		else $error("adc memory write-back wrong");
	a_adcw_imm_write: assert property (exec_ce && op_r == OP_ADCW_I |->
		ram_we && ram_addr == addr_r && ram_wdata == 4'(ram_rdata + imm_r + {3'h0, carry_r}))
		else $error("adc working register write-back wrong");
	a_add_mem_nocin: assert property (exec_ce && op_r == OP_ADD_M |=>
		accumulator == 4'($past(ram_rdata) + $past(acc_r)))
		else $error("add memory sum wrong");
	a_add_imm_keep: assert property (exec_ce && op_r == OP_ADD_I |->
		!ram_we ##1 accumulator == 4'($past(ram_rdata) + $past(imm_r)))
		else $error("add immediate wrong");
	a_addw_mem_write: assert property (exec_ce && op_r == OP_ADDW_M |->
		ram_we && ram_wdata == 4'(ram_rdata + acc_r) ##1 accumulator == $past(ram_wdata))
		else $error("add memory write-back wrong");
	a_addw_imm_write: assert property (exec_ce && op_r == OP_ADDW_I |->
		ram_we && ram_wdata == 4'(ram_rdata + imm_r) ##1 accumulator == $past(ram_wdata))
		else $error("add working register write-back wrong");
	a_adu_carry_kept: assert property (exec_ce && op_r == OP_ADU_M |->
		!ram_we ##1 $stable(carry_flag) && zero_flag == (accumulator == 4'h0)
		&& accumulator == 4'($past(ram_rdata) + $past(acc_r)))
		else $error("keep-carry add disturbed carry or memory");
	a_carry_bit3: assert property (exec_ce && op_r != OP_ADU_M |=>
		carry_flag == 1'(({1'b0, $past(ram_rdata)} + {1'b0, $past(operand_b)}
		+ {4'h0, $past(cin)}) >> 4))
		else $error("carry not taken from bit 3");
	a_zero_result: assert property (exec_ce |=> zero_flag == (accumulator == 4'h0))
		else $error("zero flag mismatch");
	a_one_cycle: assert property (s_take_legal ##1 s_exec_step |=> done_r && ready_r)
		else $error("instruction did not finish in one cycle");
	a_wr_window: assert property (s_take_imm |=>
		addr_r == 7'(`NA_WR_BASE + {3'h0, $past(instr[3:0])}))
		else $error("working register address wrong");

endmodule // nibble_add_instruction_unit

`default_nettype wire

// ---- core/nibble_add_pkg.sv ----
// types shared by the nibble add unit
package nibble_add_pkg;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_ADC_M = 4'h1,
		OP_ADC_I = 4'h2,
		OP_ADCW_M = 4'h3,
		OP_ADCW_I = 4'h4,
		OP_ADD_M = 4'h5,
		OP_ADD_I = 4'h6,
		OP_ADDW_M = 4'h7,
		OP_ADDW_I = 4'h8,
		OP_ADU_M = 4'h9
	} op_t;

	typedef enum logic [0:0] {
		S_IDLE = 1'b0,
		S_EXEC = 1'b1
	} state_t;

endpackage

// ---- core/nibble_ram.sv ----
// data memory of nibbles with registered read data
`timescale 1ns/1ps
`default_nettype none

module nibble_ram #(
	parameter int DEPTH = 128,
	parameter int AW = 7,
	parameter int DW = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	// access port
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] rdata_nxt;

	// read-before-write: a write returns the old contents
	always_comb begin
		rdata_nxt = mem[addr];
	end

	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (en) begin
			rdata <= rdata_nxt;
		end
	end

endmodule // nibble_ram

`default_nettype wire

// ---- dv/nibble_add_instruction_unit_bench.sv ----
// self-checking bench of the nibble add instruction unit
`timescale 1ns/1ps
`default_nettype none
`include "nibble_add_consts.svh"

module nibble_add_instruction_unit_bench;

	typedef struct packed {
		logic [15:0] w;
		logic [3:0] acc;
		logic c;
		logic z;
		logic [6:0] ma;
		logic [3:0] mv;
	} row_t;

	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic instr_valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic ext_we = 1'b0;
	logic ext_re = 1'b0;
	logic [6:0] ext_addr = 7'h00;
	logic [3:0] ext_wdata = 4'h0;
	logic ready, done, illegal, carry_flag, zero_flag, ext_rvalid;
	logic [3:0] accumulator, ext_rdata;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;

	// --------------------------------
	// ordinary cases, run in order; each leans on the state the row before left
	// --------------------------------
	row_t rows [11] = '{
		{{`NA_PFX_ADD_M, 7'h40}, 4'h7, 1'b0, 1'b0, 7'h40, 4'h7},
		{{`NA_PFX_ADC_M, 7'h7F}, 4'h6, 1'b1, 1'b0, 7'h7F, 4'hF},
		{{`NA_PFX_ADC_I, 4'hA, 4'h5}, 4'h4, 1'b1, 1'b0, 7'h05, 4'h9},
		{{`NA_PFX_ADU_M, 7'h40}, 4'hB, 1'b1, 1'b0, 7'h40, 4'h7},
		{{`NA_PFX_ADD_I, 4'h7, 4'h5}, 4'h0, 1'b1, 1'b1, 7'h05, 4'h9},
		{{`NA_PFX_ADCW_I, 4'h6, 4'hA}, 4'hA, 1'b0, 1'b0, 7'h0A, 4'hA},
		{{`NA_PFX_ADCW_M, 7'h40}, 4'h1, 1'b1, 1'b0, 7'h40, 4'h1},
		{{`NA_PFX_ADDW_M, 7'h7F}, 4'h0, 1'b1, 1'b1, 7'h7F, 4'h0},
		{{`NA_PFX_ADDW_I, 4'h8, 4'h5}, 4'h1, 1'b1, 1'b0, 7'h05, 4'h1},
		{{`NA_PFX_ADD_I, 4'h0, 4'hA}, 4'hA, 1'b0, 1'b0, 7'h0A, 4'hA},
		{{`NA_PFX_ADU_M, 7'h0A}, 4'h4, 1'b0, 1'b0, 7'h0A, 4'hA}
	};

	nibble_add_instruction_unit uut (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.instr_valid(instr_valid),
		.instr(instr),
		.ready(ready),
		.done(done),
		.illegal(illegal),
		.accumulator(accumulator),
		.carry_flag(carry_flag),
		.zero_flag(zero_flag),
		.ext_we(ext_we),
		.ext_re(ext_re),
		.ext_addr(ext_addr),
		.ext_wdata(ext_wdata),
		.ext_rdata(ext_rdata),
		.ext_rvalid(ext_rvalid)
	);

	always #4 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			close_out();
		end
	end

	// --------------------------------
	// helpers
	// --------------------------------
	task automatic chk4(string n, logic [3:0] e, logic [3:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(string n, logic e, logic g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask

	// bounded wait for done (rd=0) or ext_rvalid (rd=1)
	task automatic wait_for(bit rd);
		int i;
		for (i = 0; i < 6; i++) begin
			@(posedge clk);
			#1;
			if ((rd ? ext_rvalid : done) === 1'b1)
				break;
		end
		if (rd)
			chk1("ext_rvalid", 1'b1, ext_rvalid);
		else
			chk1("done", 1'b1, done);
	endtask

	task automatic mem_wr(logic [6:0] a, logic [3:0] d);
		@(posedge clk);
		ext_we <= 1'b1;
		ext_addr <= a;
		ext_wdata <= d;
		@(posedge clk);
		ext_we <= 1'b0;
	endtask

	task automatic mem_chk(logic [6:0] a, logic [3:0] e);
		@(posedge clk);
		ext_re <= 1'b1;
		ext_addr <= a;
		@(posedge clk);
		ext_re <= 1'b0;
		wait_for(1);
		chk4("ext_rdata", e, ext_rdata);
	endtask

	task automatic exec(logic [15:0] w);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= w;
		@(posedge clk);
		instr_valid <= 1'b0;
		wait_for(0);
	endtask

	task automatic rst_chk();
		chk4("accumulator", 4'h0, accumulator);
		chk1("carry_flag", 1'b0, carry_flag);
		chk1("zero_flag", 1'b0, zero_flag);
		chk1("ready", 1'b1, ready);
		chk1("done", 1'b0, done);
		chk1("illegal", 1'b0, illegal);
		chk1("ext_rvalid", 1'b0, ext_rvalid);
		chk4("ext_rdata", 4'h0, ext_rdata);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_chk();
		rstn <= 1'b1;
		mem_wr(7'h40, 4'h7);
		mem_wr(7'h7F, 4'hF);
		mem_wr(7'h05, 4'h9);
		mem_wr(7'h0A, 4'h3);
		mem_wr(7'h0B, 4'h0);
		foreach (rows[i]) begin
			exec(rows[i].w);
			chk4("accumulator", rows[i].acc, accumulator);
			chk1("carry_flag", rows[i].c, carry_flag);
			chk1("zero_flag", rows[i].z, zero_flag);
			mem_chk(rows[i].ma, rows[i].mv);
		end
		// undecodable word: one-cycle pulse right after the take, state kept
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= 16'hFFFF;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		chk1("illegal", 1'b1, illegal);
		chk1("ready", 1'b1, ready);
		chk4("accumulator", 4'h4, accumulator);
		@(posedge clk);
		#1;
		chk1("illegal", 1'b0, illegal);
		// valid held high: two takes two cycles apart, each a write-back
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= {`NA_PFX_ADDW_I, 4'h1, 4'hB};
		repeat (2) @(posedge clk);
		#1;
		chk1("done", 1'b1, done);
		chk4("accumulator", 4'h1, accumulator);
		@(posedge clk);
		instr_valid <= 1'b0;
		wait_for(0);
		chk4("accumulator", 4'h2, accumulator);
		mem_chk(7'h0B, 4'h2);
		// clock enable low freezes the execute step
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= {`NA_PFX_ADD_I, 4'h3, 4'hB};
		@(posedge clk);
		instr_valid <= 1'b0;
		ce <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk1("done", 1'b0, done);
		chk1("ready", 1'b0, ready);
		@(posedge clk);
		ce <= 1'b1;
		wait_for(0);
		chk4("accumulator", 4'h5, accumulator);
		// second reset in mid-run
		@(posedge clk);
		rstn <= 1'b0;
		#2;
		rst_chk();
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		rst_chk();
		// memory survives reset; the unit works again from a cleared accumulator
		exec({`NA_PFX_ADD_M, 7'h40});
		chk4("accumulator", 4'h1, accumulator);
		chk1("carry_flag", 1'b0, carry_flag);
		chk1("zero_flag", 1'b0, zero_flag);
		close_out();
	end

endmodule // nibble_add_instruction_unit_bench
`default_nettype wire
